// [rtl/dcp_bank_table.v]
// Open-row flags, one per bank, with registered any-open output
`timescale 1ns/1ps
module dcp_bank_table (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // Updates
   input  wire        open_i,
   input  wire        close_i,
   input  wire        close_all_i,
   input  wire [3:0]  bank_i,
   // Status
   output reg         any_open_o
);
   reg  [15:0] open_reg;  // Open flag per bank
   genvar g;
   // ----------------------------------------
   // Per-bank flags
   // ----------------------------------------
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_bank
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               open_reg[g] <= 1'b0;
            end else if (open_i && bank_i == g) begin
               open_reg[g] <= 1'b1;
            end else if (close_all_i || (close_i && bank_i == g)) begin
               open_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate
   // Registered summary of open banks
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         any_open_o <= 1'b0;
      end else begin
         any_open_o <= (|open_reg & ~close_all_i) | open_i;
      end
   end
endmodule // dcp_bank_table

// [rtl/dcp_busy_timer.v]
// Down counter that holds a busy level for a loaded number of cycles
`timescale 1ns/1ps
module dcp_busy_timer (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // Load
   input  wire        load_i,
   input  wire [4:0]  count_i,
   // Status
   output wire        busy_o
);
   reg  [4:0] cnt_reg;  // Remaining cycles
   // Load or count down
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 5'h00;
      end else if (load_i) begin
         cnt_reg <= count_i;
      end else if (cnt_reg != 5'h00) begin
         cnt_reg <= cnt_reg - 5'h01;
      end
   end
   assign busy_o = (cnt_reg != 5'h00);
endmodule // dcp_busy_timer

// [rtl/dcp_cke_ctrl.v]
// Device-side clock-enable power state, command decode and DLL-off control
`timescale 1ns/1ps
`include "dcp_consts.vh"
module dcp_cke_ctrl (
   // Clock and reset
   input  wire        clk_i,
   input  wire        resetn_i,
   // Command pins from the controller
   input  wire        cke_i,
   input  wire        cs_n_i,
   input  wire        act_n_i,
   input  wire        ras_n_i,
   input  wire        cas_n_i,
   input  wire        we_n_i,
   input  wire        odt_i,
   input  wire [3:0]  bank_i,
   input  wire [1:0]  mr_sel_i,
   input  wire        addr_a0_i,
   input  wire        addr_a10_i,
   // Mode inputs
   input  wire        gear_down_i,
   input  wire        max_pwr_save_i,
   input  wire [4:0]  add_lat_i,
   // State outputs
   output reg  [3:0]  state_o,
   output reg         idle_o,
   output reg         odt_en_o,
   output reg         self_ref_o,
   output reg         refresh_en_o,
   output reg         illegal_o,
   // DLL and command outputs
   output reg         dll_on_o,
   output reg  [4:0]  cas_lat_o,
   output reg  [4:0]  cas_wr_lat_o,
   output reg  [4:0]  dqsck_ref_o,
   output reg         cmd_valid_o,
   output reg  [3:0]  cmd_o
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   reg        rst_s1_reg;   // First reset stage
   reg        rst_n;        // Released reset
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg  [15:0] pin_s1_reg;  // First stage, read only by second
   reg  [15:0] pin_reg;     // Second stage
   wire [15:0] pin_raw = {cke_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, odt_i,
                          bank_i, mr_sel_i, addr_a0_i, addr_a10_i, 1'b0};
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= 16'h0000;
         pin_reg    <= 16'h0000;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_reg    <= pin_s1_reg;
      end
   end
   wire       cke_now  = pin_reg[15];
   wire       cs_n     = pin_reg[14];
   wire [3:0] cmd_bits = pin_reg[13:10];
   wire [3:0] bank     = pin_reg[8:5];
   wire [1:0] mr_sel   = pin_reg[4:3];
   wire       a0       = pin_reg[2];
   wire       a10      = pin_reg[1];
   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   reg        cke_prev_reg;  // CKE at previous edge
   wire       des      = cs_n;
   wire       nop      = !cs_n && cmd_bits == `DCP_CMD_NOP;
   wire       is_act   = !cs_n && !cmd_bits[3];
   wire       is_ref   = !cs_n && cmd_bits == `DCP_CMD_REF;
   wire       is_pre   = !cs_n && cmd_bits == `DCP_CMD_PRE;
   wire       is_wr    = !cs_n && cmd_bits == `DCP_CMD_WR;
   wire       is_rd    = !cs_n && cmd_bits == `DCP_CMD_RD;
   wire       is_mrs   = !cs_n && cmd_bits == `DCP_CMD_MRS;
   wire       nop_ok   = gear_down_i | max_pwr_save_i;
   // Timers and bank table
   reg        burst_ld;  // Start burst timer
   reg        pre_ld;    // Start precharge timer
   reg        ref_ld;    // Start refresh timer
   reg        exit_ld;   // Start exit timer
   wire       burst_busy;
   wire       pre_busy;
   wire       ref_busy;
   wire       exit_busy;
   wire       any_open;
   reg  [3:0] state_reg;   // Current device state
   reg  [3:0] state_next;
   reg        illegal_next;
   wire       live     = (state_reg != `DCP_ST_PPD) && (state_reg != `DCP_ST_APD)
                         && (state_reg != `DCP_ST_SREF) && cke_prev_reg && cke_now;
   dcp_busy_timer u_burst (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .load_i  (burst_ld),
      .count_i (`DCP_BURST_CYC),
      .busy_o  (burst_busy)
   );
   dcp_busy_timer u_pre (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .load_i  (pre_ld),
      .count_i (`DCP_PRE_CYC),
      .busy_o  (pre_busy)
   );
   dcp_busy_timer u_ref (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .load_i  (ref_ld),
      .count_i (`DCP_REF_CYC),
      .busy_o  (ref_busy)
   );
   dcp_busy_timer u_exit (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .load_i  (exit_ld),
      .count_i (`DCP_EXIT_CYC),
      .busy_o  (exit_busy)
   );
   dcp_bank_table u_banks (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n),
      .open_i      (live && is_act),
      .close_i     (live && is_pre && !a10),
      .close_all_i (live && is_pre && a10),
      .bank_i      (bank),
      .any_open_o  (any_open)
   );
   // Idle: banks closed, no burst, CKE high, timings elapsed
   wire       idle_now = !any_open && !burst_busy && !pre_busy && !ref_busy
                         && !exit_busy && cke_now;
   // ----------------------------------------
   // State transitions on CKE history
   // ----------------------------------------
   always @* begin
      state_next   = state_reg;
      illegal_next = 1'b0;
      burst_ld     = 1'b0;
      pre_ld       = 1'b0;
      ref_ld       = 1'b0;
      exit_ld      = 1'b0;
      case (state_reg)
         `DCP_ST_PPD, `DCP_ST_APD, `DCP_ST_SREF: begin
            // Pins ignored while low; exit on rising CKE
            if (!cke_prev_reg && cke_now) begin
               if (des || (state_reg == `DCP_ST_SREF && nop && nop_ok)) begin
                  exit_ld    = 1'b1;
                  state_next = (state_reg == `DCP_ST_APD) ? `DCP_ST_ACTIVE : `DCP_ST_IDLE;
               end else begin
                  illegal_next = 1'b1;
               end
            end
         end
         default: begin
            if (cke_prev_reg && !cke_now) begin
               if (is_ref && state_reg == `DCP_ST_IDLE && idle_o) begin
                  state_next = `DCP_ST_SREF;
               end else if (des) begin
                  // Type chosen by banks left open
                  state_next = any_open ? `DCP_ST_APD : `DCP_ST_PPD;
               end else begin
                  illegal_next = 1'b1;
               end
            end else if (live) begin
               // Normal command flow
               if (is_rd || is_wr) begin
                  burst_ld   = 1'b1;
                  state_next = is_rd ? `DCP_ST_READ : `DCP_ST_WRITE;
               end else if (is_pre) begin
                  pre_ld     = 1'b1;
                  state_next = `DCP_ST_PRECH;
               end else if (is_ref) begin
                  ref_ld     = 1'b1;
                  state_next = `DCP_ST_REFR;
               end else if (nop && !nop_ok) begin
                  illegal_next = 1'b1;
               end else if (!burst_busy && !pre_busy && !ref_busy) begin
                  state_next = (any_open || is_act) ? `DCP_ST_ACTIVE : `DCP_ST_IDLE;
               end
            end
         end
      endcase
   end
   // State register and previous CKE
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= `DCP_ST_IDLE;
         cke_prev_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cke_prev_reg <= cke_now;
      end
   end
   // ----------------------------------------
   // DLL control from mode register 1
   // ----------------------------------------
   reg        dll_reg;  // DLL enable
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dll_reg <= `DCP_DLL_RST;
      end else if (live && is_mrs && mr_sel == `DCP_MR1_SEL) begin
         dll_reg <= a0;
      end
   end
   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_o      <= `DCP_ST_IDLE;
         idle_o       <= 1'b0;
         odt_en_o     <= 1'b0;
         self_ref_o   <= 1'b0;
         refresh_en_o <= 1'b0;
         illegal_o    <= 1'b0;
         dll_on_o     <= `DCP_DLL_RST;
         cas_lat_o    <= `DCP_DLLOFF_CL;
         cas_wr_lat_o <= `DCP_DLLOFF_CWL;
         dqsck_ref_o  <= `DCP_AL_RST;
         cmd_valid_o  <= 1'b0;
         cmd_o        <= `DCP_CMD_NOP;
      end else begin
         state_o      <= state_next;
         idle_o       <= idle_now && state_next == `DCP_ST_IDLE;
         odt_en_o     <= pin_reg[9] && state_next != `DCP_ST_SREF;
         self_ref_o   <= state_next == `DCP_ST_SREF;
         // No own refresh in power-down
         refresh_en_o <= state_next == `DCP_ST_SREF;
         illegal_o    <= illegal_next;
         dll_on_o     <= dll_reg;
         if (!dll_reg) begin
            cas_lat_o    <= `DCP_DLLOFF_CL;
            cas_wr_lat_o <= `DCP_DLLOFF_CWL;
            dqsck_ref_o  <= add_lat_i + `DCP_DLLOFF_CL - 5'h01;
         end else begin
            cas_lat_o    <= `DCP_DLLOFF_CL;
            cas_wr_lat_o <= `DCP_DLLOFF_CWL;
            dqsck_ref_o  <= add_lat_i + `DCP_DLLOFF_CL;
         end
         cmd_valid_o  <= live && !des && !nop;
         cmd_o        <= cmd_bits;
      end
   end
endmodule // dcp_cke_ctrl

// [rtl/dcp_consts.vh]
// Constants for the clock-enable power state and DLL-off control block
// Summary of operation
// - Decode command from strobes and CKE at edge
// - Compare CKE now with previous edge
// - Power-down type set by banks closed at end
// - Self-refresh only from idle with refresh command
// - Self-refresh exit deselect, NOP in two modes
// - No internal refresh while in power-down
// - Termination off in self-refresh, ignored for CKE
// - Command and address ignored while powered down
// - Idle means banks closed, no burst, timings met
// - Unlisted combinations flagged as illegal
// - Deselect starts nothing, running work continues
// - Clearing DLL bit disables DLL until set
// - DLL-off uses CAS latency 10, write latency 9
// - DLL-off strobe reference one cycle earlier
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH
// ----------------------------------------
// Command codes {act_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define DCP_CMD_NOP       4'hf
`define DCP_CMD_REF       4'h9
`define DCP_CMD_PRE       4'ha
`define DCP_CMD_WR        4'hc
`define DCP_CMD_RD        4'hd
`define DCP_CMD_MRS       4'h8
// ----------------------------------------
// Device states
// ----------------------------------------
`define DCP_ST_IDLE       4'h0
`define DCP_ST_ACTIVE     4'h1
`define DCP_ST_READ       4'h2
`define DCP_ST_WRITE      4'h3
`define DCP_ST_PRECH      4'h4
`define DCP_ST_REFR       4'h5
`define DCP_ST_PPD        4'h6
`define DCP_ST_APD        4'h7
`define DCP_ST_SREF       4'h8
// ----------------------------------------
// Latencies and busy counts in cycles, reset values and MR1 select
// ----------------------------------------
`define DCP_DLLOFF_CL     5'h0a
`define DCP_DLLOFF_CWL    5'h09
`define DCP_BURST_CYC     5'h04
`define DCP_PRE_CYC       5'h04
`define DCP_REF_CYC       5'h0e
`define DCP_EXIT_CYC      5'h08
`define DCP_DLL_RST       1'h1
`define DCP_AL_RST        5'h00
`define DCP_MR1_SEL       2'h1
`endif

// [test/dcp_cke_ctrl_chk.sv]
// Concurrent checks on the clock-enable power state block ports
`timescale 1ns/1ps
`include "dcp_consts.vh"
module dcp_cke_ctrl_chk (
   // Clock and reset
   input wire       clk_i,
   input wire       resetn_i,
   // Pins
   input wire       cke_i,
   input wire       cs_n_i,
   input wire       act_n_i,
   input wire       ras_n_i,
   input wire       cas_n_i,
   input wire       we_n_i,
   input wire [4:0] add_lat_i,
   // Outputs
   input wire [3:0] state_o,
   input wire       idle_o,
   input wire       odt_en_o,
   input wire       self_ref_o,
   input wire       refresh_en_o,
   input wire       dll_on_o,
   input wire [4:0] cas_lat_o,
   input wire [4:0] cas_wr_lat_o,
   input wire [4:0] dqsck_ref_o,
   input wire       cmd_valid_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ----------------------------------------
   // Entry and exit sequences
   // ----------------------------------------
   sequence s_sre_req;
      cke_i && cs_n_i ##1 !cke_i && !cs_n_i && {act_n_i, ras_n_i, cas_n_i, we_n_i} == `DCP_CMD_REF;
   endsequence
   sequence s_srx_req;
      !cke_i ##1 cke_i && cs_n_i;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_SRE: assert property (s_sre_req ##2 idle_o |=> self_ref_o && state_o == `DCP_ST_SREF)
      else $error("self refresh not entered");
   AST_SRX: assert property (s_srx_req ##1 state_o == `DCP_ST_SREF |-> ##2 state_o == `DCP_ST_IDLE)
      else $error("self refresh exit missed");
   AST_SR_ODT: assert property (self_ref_o |-> !odt_en_o)
      else $error("termination on in self refresh");
   AST_SR_HOLD: assert property (state_o == `DCP_ST_SREF && !$past(cke_i, 2) |=> state_o == `DCP_ST_SREF)
      else $error("self refresh left with clock enable low");
   AST_PD_HOLD: assert property ((state_o == `DCP_ST_PPD || state_o == `DCP_ST_APD) && !$past(cke_i, 2)
                                 |=> $stable(state_o))
      else $error("power-down state moved");
   AST_PD_NOREF: assert property (state_o == `DCP_ST_PPD || state_o == `DCP_ST_APD |-> !refresh_en_o)
      else $error("refresh running in power-down");
   AST_PD_ENTRY: assert property ((state_o == `DCP_ST_PPD || state_o == `DCP_ST_APD) && $changed(state_o)
                                  |-> $past(cs_n_i, 3) && !$past(cke_i, 3) && $past(cke_i, 4))
      else $error("power-down entered without cause");
   AST_DES: assert property (cmd_valid_o |-> !$past(cs_n_i, 3))
      else $error("command started while deselected");
   AST_LAT: assert property (cas_lat_o == `DCP_DLLOFF_CL && cas_wr_lat_o == `DCP_DLLOFF_CWL)
      else $error("latency values wrong");
   AST_DQSCK: assert property ($stable(dll_on_o) && !dll_on_o |-> dqsck_ref_o == $past(add_lat_i) + 5'h09)
      else $error("strobe reference wrong in DLL-off");
endmodule // dcp_cke_ctrl_chk
bind dcp_cke_ctrl dcp_cke_ctrl_chk dcp_cke_ctrl_chk_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(cke_i),
   .cs_n_i(cs_n_i), .act_n_i(act_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
   .add_lat_i(add_lat_i), .state_o(state_o), .idle_o(idle_o), .odt_en_o(odt_en_o), .self_ref_o(self_ref_o),
   .refresh_en_o(refresh_en_o), .dll_on_o(dll_on_o), .cas_lat_o(cas_lat_o), .cas_wr_lat_o(cas_wr_lat_o),
   .dqsck_ref_o(dqsck_ref_o), .cmd_valid_o(cmd_valid_o));

// [test/dcp_ctl_model.sv]
// Memory controller model driving clock enable and command pins
`timescale 1ns/1ps
module dcp_ctl_model (
   // Clock
   input  wire       clk_i,
   // Command pins
   output reg        cke_o,
   output reg        cs_n_o,
   output reg  [3:0] code_o,
   output reg        odt_o,
   output reg  [3:0] bank_o,
   output reg  [1:0] mr_sel_o,
   output reg        a0_o,
   output reg        a10_o
);
   // Idle deselected with clock enable high
   initial begin
      cke_o = 1'b1; cs_n_o = 1'b1; code_o = 4'hf; odt_o = 1'b0;
      bank_o = 4'h2; mr_sel_o = 2'h0; a0_o = 1'b1; a10_o = 1'b0;
   end
   // One command cycle from a falling edge, then deselect
   task send(input c, input s, input [3:0] code, input [1:0] mr, input a0v, input a10v);
      begin
         cke_o = c;
         cs_n_o = s;
         code_o = code;
         mr_sel_o = mr;
         a0_o = a0v;
         a10_o = a10v;
         odt_o = ~odt_o;   // Termination wiggles freely
         @(negedge clk_i);
         cs_n_o = 1'b1;
         code_o = ~code_o; // Released lines scrambled
         bank_o = ~bank_o;
         a0_o = ~a0_o;
         a10_o = ~a10_o;
      end
   endtask
endmodule // dcp_ctl_model

// [test/tb_dcp_cke_ctrl.sv]
// Self-checking bench for the clock-enable power state block
`timescale 1ns/1ps
`include "dcp_consts.vh"
module tb_dcp_cke_ctrl;
   reg        clk_i = 1'b0;  // 40 MHz clock
   reg        resetn_i = 1'b0;
   reg        gear_down_i = 1'b0;
   reg        max_pwr_save_i = 1'b0;
   reg  [4:0] add_lat_i = 5'h03;
   wire       cke, cs_n, odt, a0, a10;
   wire [3:0] code, bank, state_o, cmd_o;
   wire [1:0] mr_sel;
   wire       idle_o, odt_en_o, self_ref_o, refresh_en_o, illegal_o, dll_on_o, cmd_valid_o;
   wire [4:0] cas_lat_o, cas_wr_lat_o, dqsck_ref_o;
   integer    err_count = 0;
   integer    n_checks = 0;
   integer    cyc = 0;
   always #12.5 clk_i = ~clk_i;
   dcp_ctl_model dcp_ctl_model_inst (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .code_o(code), .odt_o(odt),
      .bank_o(bank), .mr_sel_o(mr_sel), .a0_o(a0), .a10_o(a10));
   dcp_cke_ctrl dcp_cke_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(cke), .cs_n_i(cs_n),
      .act_n_i(code[3]), .ras_n_i(code[2]), .cas_n_i(code[1]), .we_n_i(code[0]), .odt_i(odt), .bank_i(bank),
      .mr_sel_i(mr_sel), .addr_a0_i(a0), .addr_a10_i(a10), .gear_down_i(gear_down_i),
      .max_pwr_save_i(max_pwr_save_i), .add_lat_i(add_lat_i), .state_o(state_o), .idle_o(idle_o),
      .odt_en_o(odt_en_o), .self_ref_o(self_ref_o), .refresh_en_o(refresh_en_o), .illegal_o(illegal_o),
      .dll_on_o(dll_on_o), .cas_lat_o(cas_lat_o), .cas_wr_lat_o(cas_wr_lat_o), .dqsck_ref_o(dqsck_ref_o),
      .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o));
   // Compare and count
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // Verdict and end of run
   task stop_test;
      begin
         if (err_count == 0 && n_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // Hang guard
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_count = err_count + 1;
         stop_test;
      end
   end
   task send(input c, input s, input [3:0] k, input [1:0] mr, input a0v, input a10v);
      dcp_ctl_model_inst.send(c, s, k, mr, a0v, a10v);
   endtask
   // Three cycles of pipeline before outputs move
   task settle;
      repeat (3) @(negedge clk_i);
   endtask
   // Two cycles: one-cycle pulses stand here
   task pulse;
      repeat (2) @(negedge clk_i);
   endtask
   // Bounded wait for the idle flag
   task wait_idle;
      integer k;
      begin
         k = 0;
         while (idle_o !== 1'b1 && k < 100) begin
            @(negedge clk_i);
            k = k + 1;
         end
         chk(idle_o, 8'h01);
      end
   endtask
   // Reset values and DLL control
   task t_dll;
      begin
         chk({dll_on_o, state_o}, 8'h10);
         chk({cas_lat_o, cas_wr_lat_o[2:0]}, 8'h51);
         send(1'b1, 1'b0, `DCP_CMD_MRS, 2'h0, 1'b0, 1'b0);
         settle;
         chk(dll_on_o, 8'h01);
         send(1'b1, 1'b0, `DCP_CMD_MRS, `DCP_MR1_SEL, 1'b0, 1'b0);
         settle;
         chk({dll_on_o, dqsck_ref_o}, 8'h0c);
         send(1'b1, 1'b0, `DCP_CMD_MRS, `DCP_MR1_SEL, 1'b1, 1'b0);
         settle;
         chk({dll_on_o, dqsck_ref_o}, 8'h2d);
      end
   endtask
   // Self refresh entry, ignored pins and every exit mode
   task t_sref;
      integer m;
      begin
         for (m = 0; m < 3; m = m + 1) begin
            wait_idle;
            gear_down_i = (m == 1);
            max_pwr_save_i = (m == 2);
            send(1'b1, 1'b1, 4'hf, 2'h0, 1'b1, 1'b0);
            send(1'b0, 1'b0, `DCP_CMD_REF, 2'h0, 1'b1, 1'b0);
            settle;
            chk({self_ref_o, refresh_en_o, odt_en_o, state_o}, 8'h68);
            send(1'b0, 1'b0, `DCP_CMD_WR, 2'h1, 1'b0, 1'b1);
            pulse;
            chk({illegal_o, state_o}, 8'h08);
            send(1'b1, (m == 0), `DCP_CMD_NOP, 2'h0, 1'b1, 1'b0);
            settle;
            chk({idle_o, odt_en_o, self_ref_o, state_o}, 8'h20);
         end
         gear_down_i = 1'b0;
         max_pwr_save_i = 1'b0;
      end
   endtask
   // Active and precharge power-down, deselect behaviour
   task t_pd;
      begin
         wait_idle;
         send(1'b1, 1'b1, `DCP_CMD_RD, 2'h0, 1'b1, 1'b0);
         pulse;
         chk(cmd_valid_o, 8'h00);
         send(1'b1, 1'b0, 4'h7, 2'h0, 1'b1, 1'b0);
         pulse;
         chk({cmd_valid_o, cmd_o, state_o[2:0]}, 8'hb9);
         send(1'b0, 1'b1, 4'hf, 2'h0, 1'b1, 1'b0);
         settle;
         chk({refresh_en_o, state_o}, 8'h07);
         send(1'b0, 1'b0, `DCP_CMD_RD, 2'h0, 1'b1, 1'b0);
         settle;
         chk(state_o, 8'h07);
         send(1'b1, 1'b1, 4'hf, 2'h0, 1'b1, 1'b0);
         settle;
         chk(state_o, 8'h01);
         send(1'b1, 1'b0, `DCP_CMD_PRE, 2'h0, 1'b1, 1'b1);
         wait_idle;
         send(1'b0, 1'b1, 4'hf, 2'h0, 1'b1, 1'b0);
         settle;
         chk(state_o, 8'h06);
         send(1'b1, 1'b1, 4'hf, 2'h0, 1'b1, 1'b0);
         settle;
         chk(state_o, 8'h00);
      end
   endtask
   // Unlisted combinations flagged
   task t_illegal;
      begin
         wait_idle;
         send(1'b1, 1'b0, `DCP_CMD_NOP, 2'h0, 1'b1, 1'b0);
         pulse;
         chk(illegal_o, 8'h01);
         send(1'b0, 1'b0, `DCP_CMD_WR, 2'h0, 1'b1, 1'b0);
         pulse;
         chk(illegal_o, 8'h01);
      end
   endtask
   // Main sequence
   initial begin
      repeat (12) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (6) @(negedge clk_i);
      t_dll;
      t_sref;
      t_pd;
      t_illegal;
      stop_test;
   end
endmodule // tb_dcp_cke_ctrl
